// ---- verilog/mos_defs.svh ----
/*
  Constants of the metrology output scaling block: full-scale codes, field
  positions, encodings and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MOS_DEFS_SVH
`define MOS_DEFS_SVH

// ==========================================================================
// full-scale codes
`define MOS_RMS_FS_CODES     32'h0665_6EF8
`define MOS_POW_FS_CODES     32'h051D_A5B0
`define MOS_PCF_FS_CODES     32'h0066_5563
`define MOS_NORM_FULL_SCALE  32'h4000_0000

// ==========================================================================
// fixed-point encodings
`define MOS_NORM_FRAC_BITS   30
`define MOS_PF_SHIFT         3
`define MOS_ENERGY_LO_BITS   13
`define MOS_ANGLE_SHIFT      8
`define MOS_PERIOD_BIAS      32'h0000_0001

// ==========================================================================
// meter constant range, impulses per kilowatt-hour
`define MOS_MC_MIN           16'h0064
`define MOS_MC_MAX           16'h2710

// ==========================================================================
// configuration fields
`define MOS_DERIVE_B_BIT     0
`define MOS_SRC_LSB          5
`define MOS_SRC_MSB          6

// ==========================================================================
// reset values
`define MOS_RESET_WORD       32'h0000_0000
`define MOS_RESET_SAMPLE     24'h00_0000
`define MOS_RESET_MC         16'h0064

`endif

// ---- verilog/mos_pkg.sv ----
/*
  Types of the metrology output scaling block.
  Assumes mos_defs.svh is available for the numeric constants.
*/
package mos_pkg;
  // ========================================================================
  // stream source select field encoding
  typedef enum logic [1:0] {
    MOS_SRC_RAW  = 2'b00,
    MOS_SRC_PCF  = 2'b01,
    MOS_SRC_RSV2 = 2'b10,
    MOS_SRC_RSV3 = 2'b11
  } mos_src_t;

  // result sequencing states
  typedef enum logic [1:0] {
    MOS_ST_IDLE  = 2'b00,
    MOS_ST_WAIT  = 2'b01
  } mos_state_t;
endpackage : mos_pkg

// ---- verilog/mos_scale_if.sv ----
/*
  Carrier between the result sequencer or stream path and the full-scale scaler.
  Assumes one clock domain; the sequencer or stream path drives load and norm.
*/
`timescale 1ns/1ps
interface mos_scale_if #(parameter int LANES = 1);
  logic                  load;    // take norm this cycle
  logic [LANES-1:0][31:0] norm;   // signed Q2.30, full scale at 1.0
  logic                  done;    // scaled valid, one cycle after load
  logic [LANES-1:0][31:0] scaled; // codes
  modport seq (output load, output norm, input done, input scaled);
  modport scl (input load, input norm, output done, output scaled);
endinterface : mos_scale_if

// ---- verilog/mos_fs_scaler.sv ----
/*
  Multiplies normalised lanes by a full-scale code in one registered step.
  Assumes signed Q2.30 inputs; 1.0 yields exactly FS_CODE.
*/
`timescale 1ns/1ps
`include "mos_defs.svh"
module mos_fs_scaler
  import mos_pkg::*;
#(
  parameter int          LANES   = 1,
  parameter logic [31:0] FS_CODE = `MOS_RMS_FS_CODES
) (
  input  wire logic core_clk, // 200 MHz
  input  wire logic arst_n,   // async reset, low
  mos_scale_if.scl  sif       // lanes in and out
);
  localparam logic signed [63:0] FS_WIDE = {32'h0000_0000, FS_CODE};

  // ==========================================================================
  // done strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) sif.done <= 1'b0;
    else         sif.done <= sif.load;
  end

  // ==========================================================================
  // per-lane product; truncation toward minus infinity keeps full scale exact
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic signed [63:0] wide;
    logic signed [63:0] prod;
    assign wide = {{32{sif.norm[i][31]}}, sif.norm[i]};
    assign prod = wide * FS_WIDE;
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)       sif.scaled[i] <= `MOS_RESET_WORD;
      else if (sif.load) sif.scaled[i] <= prod[61:30];
    end
  end

  AST_FS_CODE: assert property (@(posedge core_clk) disable iff (!arst_n)
    sif.load && sif.norm[0] == `MOS_NORM_FULL_SCALE |=> sif.scaled[0] == FS_CODE)
    else $error("full-scale input did not give the full-scale code");
  AST_SCALE_DONE: assert property (@(posedge core_clk) disable iff (!arst_n)
    sif.load |=> sif.done ##1 !sif.done || $past(sif.load))
    else $error("scaler done strobe out of step with load");
endmodule : mos_fs_scaler

// ---- verilog/mos_output_scaling.sv ----
/*
  Output formatting of a three-phase metrology result set: full-scale
  scaling, energy word split, power factor, period and angle encodings,
  derived phase-B current, stream source select and calibration pulse.
  Assumes all inputs synchronous to core_clk and upstream filtering done.
*/
`timescale 1ns/1ps
`include "mos_defs.svh"
module mos_output_scaling
  import mos_pkg::*;
#(
  parameter logic [63:0] CF_KWH_CODES = 64'h0000_0100_0000_0000 // energy codes per kWh times constant
) (
  input  wire logic             core_clk,                   // 200 MHz clock
  input  wire logic             arst_n,                     // async reset, low
  input  wire logic             sampleValid,                // new 4 kHz sample set
  input  wire logic [2:0][23:0] rawCurrent,                 // raw ADC current A,B,C
  input  wire logic [2:0][31:0] pcfNorm,                    // filtered current, Q2.30
  input  wire logic [31:0]      mainConfiguration,          // main configuration word
  input  wire logic [15:0]      streamConfiguration,        // stream configuration word
  output logic                  streamValid,                // stream sample pulse
  output logic [2:0][23:0]      streamCurrent,              // streamed current A,B,C
  input  wire logic             resultValid,                // new normalised results
  input  wire logic [17:0][31:0] rmsNorm,                   // six RMS kinds x three phases
  input  wire logic [5:0][31:0] powerNorm,                  // active A-C, apparent A-C
  input  wire logic [2:0][31:0] pfNorm,                     // power factor, Q2.30
  input  wire logic [3:0][31:0] periodFine,                 // period ticks, A,B,C,neutral
  input  wire logic [2:0][31:0] angleDelay,                 // lag ticks of three angles
  output logic                  resultReady,                // results updated pulse
  output logic [17:0][31:0]     rmsResult,                  // RMS-type codes
  output logic [5:0][31:0]      powerResult,                // power codes
  output logic [2:0][31:0]      powerFactorResult,          // power factor codes
  output logic [3:0][31:0]      linePeriodResult,           // period codes, [3] neutral
  output logic [2:0][31:0]      phaseAngleResult,           // angle codes
  input  wire logic             powerTick,                  // 4 kHz accumulation tick
  input  wire logic             energyClear,                // clear energy accumulators
  output logic [5:0][31:0]      energyHigh,                 // energy high words
  output logic [5:0][31:0]      energyLow,                  // energy low words
  input  wire logic [15:0]      meterConstant,              // impulses per kWh
  output logic                  meterConstantInvalid,       // constant was clamped
  output logic                  calibrationPulse            // one-cycle pulse
);
  // ==========================================================================
  // helpers
  function automatic logic [23:0] sat24(input logic [31:0] v);
    if (!v[31] && v[30:23] != 8'h00)     sat24 = 24'h7F_FFFF;
    else if (v[31] && v[30:23] != 8'hFF) sat24 = 24'h80_0000;
    else                                 sat24 = v[23:0];
  endfunction : sat24

  // minus (a + c), saturated; replaces a missing phase-B sensor
  function automatic logic [23:0] negSum(input logic [23:0] a, input logic [23:0] c);
    logic [31:0] s;
    s = 32'h0000_0000 - ({{8{a[23]}}, a} + {{8{c[23]}}, c});
    negSum = sat24(s);
  endfunction : negSum

  mos_state_t  state;
  logic        deriveB;
  mos_src_t    srcSel;
  logic [23:0] rawHold [3];
  logic        pcfDone;
  logic [63:0] cfAcc;
  logic [15:0] mcReg;

  mos_scale_if #(.LANES(18)) rmsIf ();
  mos_scale_if #(.LANES(6))  powIf ();
  mos_scale_if #(.LANES(3))  pcfIf ();

  assign deriveB = mainConfiguration[`MOS_DERIVE_B_BIT];
  assign srcSel  = mos_src_t'(streamConfiguration[`MOS_SRC_MSB:`MOS_SRC_LSB]);

  // ==========================================================================
  // scalers
  assign rmsIf.load = resultValid && state == MOS_ST_IDLE;
  assign rmsIf.norm = rmsNorm;
  assign powIf.load = rmsIf.load;
  assign powIf.norm = powerNorm;
  assign pcfIf.load = sampleValid;
  assign pcfIf.norm = pcfNorm;
  assign pcfDone    = pcfIf.done;

  mos_fs_scaler #(.LANES(18), .FS_CODE(`MOS_RMS_FS_CODES)) u_rms (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sif      (rmsIf.scl)
  );
  mos_fs_scaler #(.LANES(6), .FS_CODE(`MOS_POW_FS_CODES)) u_pow (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sif      (powIf.scl)
  );
  mos_fs_scaler #(.LANES(3), .FS_CODE(`MOS_PCF_FS_CODES)) u_pcf (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sif      (pcfIf.scl)
  );

  // ==========================================================================
  // result sequencing; new results are ignored while a set is in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MOS_ST_IDLE;
    end else begin
      case (state)
        MOS_ST_IDLE: if (resultValid) state <= MOS_ST_WAIT;
        MOS_ST_WAIT: if (rmsIf.done) state <= MOS_ST_IDLE;
        default:     state <= MOS_ST_IDLE;
      endcase
    end
  end

  // publish of scaled and encoded results
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultReady       <= 1'b0;
      rmsResult         <= '0;
      powerResult       <= '0;
      powerFactorResult <= '0;
      linePeriodResult  <= '0;
      phaseAngleResult  <= '0;
    end else begin
      resultReady <= state == MOS_ST_WAIT && rmsIf.done;
      if (state == MOS_ST_WAIT && rmsIf.done) begin
        rmsResult   <= rmsIf.scaled;
        powerResult <= powIf.scaled;
      end
      if (rmsIf.load) begin
        for (int k = 0; k < 3; k++) begin
          powerFactorResult[k] <= 32'($signed(pfNorm[k]) >>> `MOS_PF_SHIFT);
          phaseAngleResult[k]  <= 32'((periodFine[0] + angleDelay[k]) >> `MOS_ANGLE_SHIFT);
        end
        for (int k = 0; k < 4; k++)
          linePeriodResult[k] <= periodFine[k] - `MOS_PERIOD_BIAS;
      end
    end
  end

  // ==========================================================================
  // streaming: raw path held one cycle so both sources share latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rawHold       <= '{default: `MOS_RESET_SAMPLE};
      streamValid   <= 1'b0;
      streamCurrent <= '0;
    end else begin
      if (sampleValid) begin
        rawHold[0] <= rawCurrent[0];
        rawHold[1] <= deriveB ? negSum(rawCurrent[0], rawCurrent[2]) : rawCurrent[1];
        rawHold[2] <= rawCurrent[2];
      end
      streamValid <= pcfDone;
      if (pcfDone) begin
        if (srcSel == MOS_SRC_PCF) begin
          streamCurrent[0] <= sat24(pcfIf.scaled[0]);
          streamCurrent[1] <= deriveB ? negSum(sat24(pcfIf.scaled[0]), sat24(pcfIf.scaled[2]))
                                      : sat24(pcfIf.scaled[1]);
          streamCurrent[2] <= sat24(pcfIf.scaled[2]);
        end else begin
          // reserved codes fall back to raw samples
          streamCurrent[0] <= rawHold[0];
          streamCurrent[1] <= rawHold[1];
          streamCurrent[2] <= rawHold[2];
        end
      end
    end
  end

  // ==========================================================================
  // energy: 45-bit accumulators, high word is bits 44:13
  for (genvar e = 0; e < 6; e++) begin : g_energy
    logic [44:0] acc;
    logic [44:0] inc;
    assign inc = {{13{powerResult[e][31]}}, powerResult[e]};
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)          acc <= '0;
      else if (energyClear) acc <= powerTick ? inc : 45'h0;
      else if (powerTick)   acc <= acc + inc;
    end
    assign energyHigh[e] = acc[44:`MOS_ENERGY_LO_BITS];
    assign energyLow[e]  = {19'h0_0000, acc[`MOS_ENERGY_LO_BITS-1:0]};
  end

  // ==========================================================================
  // meter constant clamped so the pulse rate stays within range
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mcReg                <= `MOS_RESET_MC;
      meterConstantInvalid <= 1'b0;
    end else begin
      if (meterConstant < `MOS_MC_MIN)      mcReg <= `MOS_MC_MIN;
      else if (meterConstant > `MOS_MC_MAX) mcReg <= `MOS_MC_MAX;
      else                                  mcReg <= meterConstant;
      meterConstantInvalid <= meterConstant < `MOS_MC_MIN || meterConstant > `MOS_MC_MAX;
    end
  end

  // calibration pulse from net three-phase active energy; a net export does not count
  logic signed [33:0] actSum;
  logic [63:0]        cfInc;
  logic [63:0]        cfNext;
  assign actSum = 34'($signed(powerResult[0])) + 34'($signed(powerResult[1])) + 34'($signed(powerResult[2]));
  assign cfInc  = actSum[33] ? 64'h0 : {30'h0, actSum} * {48'h0, mcReg};
  assign cfNext = cfAcc + cfInc;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfAcc            <= '0;
      calibrationPulse <= 1'b0;
    end else begin
      calibrationPulse <= powerTick && cfNext >= CF_KWH_CODES;
      if (powerTick) cfAcc <= (cfNext >= CF_KWH_CODES) ? cfNext - CF_KWH_CODES : cfNext;
    end
  end

  // ==========================================================================
  // checks
  sequence sAccept;
    resultValid && state == MOS_ST_IDLE;
  endsequence
  sequence sPublish;
    ##1 (state == MOS_ST_WAIT && rmsIf.done) ##1 resultReady;
  endsequence

  AST_PUBLISH_TIMING: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept |-> sPublish)
    else $error("results not published two cycles after acceptance");
  AST_RMS_FULL: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept and rmsNorm[0] == `MOS_NORM_FULL_SCALE |-> ##2 rmsResult[0] == `MOS_RMS_FS_CODES)
    else $error("full-scale rms code wrong");
  AST_POW_FULL: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept and powerNorm[3] == `MOS_NORM_FULL_SCALE |-> ##2 powerResult[3] == `MOS_POW_FS_CODES)
    else $error("full-scale power code wrong");
  AST_PF_FORMAT: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept |=> powerFactorResult[1] == 32'($signed($past(pfNorm[1])) >>> `MOS_PF_SHIFT))
    else $error("power factor encoding wrong");
  AST_PERIOD_FORMAT: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept |=> linePeriodResult[3] + `MOS_PERIOD_BIAS == $past(periodFine[3]))
    else $error("period encoding wrong");
  AST_ANGLE_FORMAT: assert property (@(posedge core_clk) disable iff (!arst_n)
    sAccept |=> phaseAngleResult[2] == ($past(periodFine[0]) + $past(angleDelay[2])) >> `MOS_ANGLE_SHIFT)
    else $error("angle encoding wrong");
  AST_ENERGY_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    powerTick && !energyClear |=> {energyHigh[0], energyLow[0][12:0]}
      == $past({energyHigh[0], energyLow[0][12:0]}) + {{13{$past(powerResult[0][31])}}, $past(powerResult[0])})
    else $error("energy words did not accumulate power");
  AST_DERIVE_B: assert property (@(posedge core_clk) disable iff (!arst_n)
    sampleValid && deriveB && srcSel == MOS_SRC_RAW && !pcfDone
      |-> ##2 streamValid && streamCurrent[1] == negSum($past(rawCurrent[0], 2), $past(rawCurrent[2], 2)))
    else $error("derived phase-B current wrong");
  AST_STREAM_PCF: assert property (@(posedge core_clk) disable iff (!arst_n)
    pcfDone && srcSel == MOS_SRC_PCF |=> streamCurrent[0] == sat24($past(pcfIf.scaled[0])))
    else $error("stream source select ignored");
  AST_MC_RANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    meterConstant > `MOS_MC_MAX |=> mcReg == `MOS_MC_MAX && meterConstantInvalid)
    else $error("meter constant outside range");
endmodule : mos_output_scaling

// ---- tb/mos_host_model.sv ----
/*
  Host-side model of the scaling block: takes each published result set,
  each streamed current sample and each calibration pulse, and counts them.
  Assumes one clock shared with the block and one-cycle output pulses.
*/
`timescale 1ns/1ps
module mos_host_model (
  input  wire logic             core_clk,         // bench clock
  input  wire logic             arst_n,           // async reset, low
  input  wire logic             resultReady,      // publish pulse
  input  wire logic             streamValid,      // stream sample pulse
  input  wire logic [2:0][23:0] streamCurrent,    // streamed A,B,C
  input  wire logic             calibrationPulse, // pulse output
  output int                    resultCount,      // publishes seen
  output int                    streamCount,      // samples seen
  output int                    pulseCount,       // pulses seen
  output logic [2:0][23:0]      lastStream        // last sample taken
);
  // ========================================================================
  // host sampling
  // a pulse stretched past one cycle is counted once per cycle, so counts expose it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultCount <= 0;
      streamCount <= 0;
      pulseCount  <= 0;
      lastStream  <= '0;
    end else begin
      if (resultReady === 1'b1) resultCount <= resultCount + 1;
      if (calibrationPulse === 1'b1) pulseCount <= pulseCount + 1;
      if (streamValid === 1'b1) begin
        streamCount <= streamCount + 1;
        lastStream  <= streamCurrent; // taken only on the pulse itself
      end
    end
  end
endmodule : mos_host_model

// ---- tb/test_metrology_output_scaling.sv ----
/*
  Self-checking bench of the output scaling block: result encodings, stream
  source and derived current, energy words, meter constant and pulse output.
  Assumes mos_defs.svh and mos_pkg are compiled; inputs change on falling edges.
*/
`timescale 1ns/1ps
`include "mos_defs.svh"
module test_metrology_output_scaling
  import mos_pkg::*;
;
  // ========================================================================
  // signals
  localparam logic [63:0] CF_CODES = 64'h0000_0000_05F5_E100; // short pulse count
  logic                   core_clk, arst_n, sampleValid, resultValid, powerTick, energyClear;
  logic [2:0][23:0]       rawCurrent, streamCurrent, lastStream;
  logic [2:0][31:0]       pcfNorm, pfNorm, angleDelay, powerFactorResult, phaseAngleResult;
  logic [31:0]            mainConfiguration;
  logic [15:0]            streamConfiguration, meterConstant, mcExp;
  logic                   streamValid, resultReady, meterConstantInvalid, calibrationPulse;
  logic [17:0][31:0]      rmsNorm, rmsResult;
  logic [5:0][31:0]       powerNorm, powerResult, energyHigh, energyLow;
  logic [3:0][31:0]       periodFine, linePeriodResult;
  logic [31:0]            epow [6];
  logic [44:0]            eacc [6];
  logic [63:0]            cfAcc;
  int                     seed, errTotal, cmpCount, pulsesExp, nPub, nStr, resultCount, streamCount, pulseCount;

  mos_output_scaling #(.CF_KWH_CODES(CF_CODES)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .sampleValid(sampleValid), .rawCurrent(rawCurrent),
    .pcfNorm(pcfNorm), .mainConfiguration(mainConfiguration), .streamConfiguration(streamConfiguration),
    .streamValid(streamValid), .streamCurrent(streamCurrent), .resultValid(resultValid),
    .rmsNorm(rmsNorm), .powerNorm(powerNorm), .pfNorm(pfNorm), .periodFine(periodFine),
    .angleDelay(angleDelay), .resultReady(resultReady), .rmsResult(rmsResult),
    .powerResult(powerResult), .powerFactorResult(powerFactorResult),
    .linePeriodResult(linePeriodResult), .phaseAngleResult(phaseAngleResult),
    .powerTick(powerTick), .energyClear(energyClear), .energyHigh(energyHigh), .energyLow(energyLow),
    .meterConstant(meterConstant), .meterConstantInvalid(meterConstantInvalid),
    .calibrationPulse(calibrationPulse));

  mos_host_model HOST (
    .core_clk(core_clk), .arst_n(arst_n), .resultReady(resultReady), .streamValid(streamValid),
    .streamCurrent(streamCurrent), .calibrationPulse(calibrationPulse), .resultCount(resultCount),
    .streamCount(streamCount), .pulseCount(pulseCount), .lastStream(lastStream));

  // ========================================================================
  // expectation helpers
  function automatic logic [31:0] scale_fs(input logic [31:0] n, input logic [31:0] fs);
    logic signed [63:0] p;
    p = $signed({{32{n[31]}}, n}) * $signed({32'h0000_0000, fs});
    return p[61:30]; // floor of product shifted down by 30
  endfunction : scale_fs

  function automatic logic [23:0] sat24(input logic signed [25:0] x);
    if (x > 26'sh07F_FFFF) return 24'h7F_FFFF;
    if (x < -26'sh080_0000) return 24'h80_0000;
    return x[23:0];
  endfunction : sat24

  task automatic check(input string name, input logic [63:0] expv, input logic [63:0] gotv);
    cmpCount++;
    if (gotv !== expv) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", name, expv, gotv);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // ========================================================================
  // one result publish; answer is fixed at two edges, so no wait loop
  task automatic publish();
    int k;
    @(negedge core_clk);
    resultValid = 1'b1;
    check("resultReady c0", 64'h0, resultReady);
    @(negedge core_clk);
    resultValid = 1'b0;
    check("resultReady c1", 64'h0, resultReady);
    @(negedge core_clk);
    check("resultReady c2", 64'h1, resultReady);
    nPub++;
    for (k = 0; k < 18; k++) check("rmsResult", scale_fs(rmsNorm[k], `MOS_RMS_FS_CODES), rmsResult[k]);
    for (k = 0; k < 6; k++) begin
      epow[k] = scale_fs(powerNorm[k], `MOS_POW_FS_CODES);
      check("powerResult", epow[k], powerResult[k]);
    end
    for (k = 0; k < 3; k++) begin
      check("powerFactorResult", {$signed(pfNorm[k]) >>> 3}, powerFactorResult[k]);
      check("phaseAngleResult", 32'(periodFine[0] + angleDelay[k]) >> 8, phaseAngleResult[k]);
    end
    for (k = 0; k < 4; k++) check("linePeriodResult", 32'(periodFine[k] - 1), linePeriodResult[k]);
    @(negedge core_clk);
    check("resultReady c3", 64'h0, resultReady);
  endtask : publish

  // ========================================================================
  // one stream sample with a given source code and derive setting
  task automatic stream_one(input logic [1:0] src, input logic der);
    int k;
    logic [2:0][23:0] e;
    logic [31:0]      s;
    streamConfiguration = 16'($random(seed));
    streamConfiguration[6:5] = src;
    mainConfiguration = $random(seed);
    mainConfiguration[0] = der;
    @(negedge core_clk);
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
    @(negedge core_clk);
    check("streamValid c2", 64'h1, streamValid);
    nStr++;
    for (k = 0; k < 3; k++) begin
      s = scale_fs(pcfNorm[k], `MOS_PCF_FS_CODES);
      e[k] = (src == MOS_SRC_PCF) ? s[23:0] : rawCurrent[k];
    end
    if (der) e[1] = sat24(-($signed({{2{e[0][23]}}, e[0]}) + $signed({{2{e[2][23]}}, e[2]})));
    for (k = 0; k < 3; k++) check("streamCurrent", e[k], streamCurrent[k]);
    @(negedge core_clk);
    for (k = 0; k < 3; k++) check("host lastStream", e[k], lastStream[k]);
  endtask : stream_one

  // ========================================================================
  // one accumulation tick, with the energy and pulse models stepped alongside
  task automatic tick(input logic clr);
    int k;
    logic signed [33:0] sum;
    @(negedge core_clk);
    powerTick = 1'b1;
    energyClear = clr;
    for (k = 0; k < 6; k++) eacc[k] = (clr ? 45'h0 : eacc[k]) + {{13{epow[k][31]}}, epow[k]};
    sum = $signed({{2{epow[0][31]}}, epow[0]}) + $signed({{2{epow[1][31]}}, epow[1]})
        + $signed({{2{epow[2][31]}}, epow[2]});
    if (sum > 0) cfAcc = cfAcc + 64'(sum) * 64'(mcExp);
    if (cfAcc >= CF_CODES) begin
      cfAcc = cfAcc - CF_CODES;
      pulsesExp++;
    end
    @(negedge core_clk);
    powerTick = 1'b0;
    energyClear = 1'b0;
    @(negedge core_clk);
  endtask : tick

  task automatic check_energy();
    int k;
    for (k = 0; k < 6; k++) begin
      check("energyHigh", eacc[k][44:13], energyHigh[k]);
      check("energyLow", {19'h0, eacc[k][12:0]}, energyLow[k]);
    end
  endtask : check_energy

  // ========================================================================
  // clock and watchdog; the watchdog counts as a mismatch
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    complete_run();
  end

  // ========================================================================
  // main sequence
  initial begin : main_seq
    int i, k;
    logic [15:0] mcTab [6];
    mcTab = '{16'h0000, 16'h0064, 16'h2710, 16'h2711, 16'hFFFF, 16'h0063};
    seed = 25;
    {errTotal, cmpCount, pulsesExp, nPub, nStr} = '0;
    cfAcc = '0;
    {sampleValid, resultValid, powerTick, energyClear} = '0;
    rawCurrent = '0;
    pcfNorm = '0;
    mainConfiguration = '0;
    streamConfiguration = '0;
    rmsNorm = '0;
    powerNorm = '0;
    pfNorm = '0;
    periodFine = '1;
    angleDelay = '0;
    meterConstant = 16'h0064;
    for (k = 0; k < 6; k++) eacc[k] = '0;
    arst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    check("reset outputs", 64'h0, {energyHigh[0] | rmsResult[0], 29'h0, resultReady, streamValid, calibrationPulse});
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    // random result sets; one lane of each kind at full scale
    for (i = 0; i < 4; i++) begin
      for (k = 0; k < 18; k++) rmsNorm[k] = (k % 3 == 0) ? `MOS_NORM_FULL_SCALE : $random(seed) >>> 1;
      for (k = 0; k < 6; k++) powerNorm[k] = (k % 3 == 0) ? `MOS_NORM_FULL_SCALE : $random(seed) >>> 1;
      for (k = 0; k < 3; k++) pfNorm[k] = $random(seed) >>> 1;
      for (k = 0; k < 4; k++) periodFine[k] = 32'h0050_0000 + 32'($random(seed) & 32'h0000_FFFF);
      for (k = 0; k < 3; k++) angleDelay[k] = $random(seed) & 32'h000F_FFFF;
      publish();
    end
    check("rms full scale", 32'h0665_6EF8, rmsResult[0]);
    check("power full scale", 32'h051D_A5B0, {powerResult[0], powerResult[3]} >> 32);
    check("apparent full scale", 32'h051D_A5B0, powerResult[3]);
    // every source code, derive off and on
    for (i = 0; i < 8; i++) begin
      for (k = 0; k < 3; k++) rawCurrent[k] = 24'($random(seed));
      for (k = 0; k < 3; k++) pcfNorm[k] = (i == 1 && k == 0) ? `MOS_NORM_FULL_SCALE : $random(seed) >>> 2;
      stream_one(i[1:0], i[2]);
      if (i == 1) check("pcf full scale", 24'h66_5563, streamCurrent[0]);
    end
    rawCurrent = {24'hC0_0000, 24'h12_3456, 24'hC0_0000};
    stream_one(2'b00, 1'b1);
    check("derived saturates", 24'h7F_FFFF, streamCurrent[1]);
    // meter constant range, ends out of range so the clamp feeds the pulse run
    for (i = 0; i < 6; i++) begin
      @(negedge core_clk);
      meterConstant = mcTab[i];
      repeat (2) @(negedge core_clk);
      check("meterConstantInvalid", (mcTab[i] < 16'd100 || mcTab[i] > 16'd10000), meterConstantInvalid);
    end
    mcExp = 16'h0064;
    // fixed powers with a negative lane for sign extension and pulse sums
    powerNorm = {$random(seed) >>> 4, $random(seed) >>> 4, $random(seed) >>> 4,
                 32'h0010_0000, 32'hFFF0_0000, 32'h0010_0000};
    publish();
    for (i = 0; i < 60; i++) tick(1'b0);
    check_energy();
    tick(1'b1);
    check_energy();
    repeat (3) @(negedge core_clk);
    check("calibration pulses", pulsesExp, pulseCount);
    check("host results", nPub, resultCount);
    check("host samples", nStr, streamCount);
    complete_run();
  end
endmodule : test_metrology_output_scaling
